// file: hw/sesc_ctrl.sv
// Servo excitation and stop input control with APB register access
//
// Overview of operation
// [R1] Excite request energises windings first, then raises ready.
// [R2] With a brake, excitation completes before the brake releases.
// [R3] Excite request removed: ready drops first, then excitation is removed.
// [R4] With a brake, brake engages before excitation is removed.
// [R5] Free-run cuts motor current and releases any holding brake.
// [R6] Energised: free-run drops ready then de-energises; release reverses it.
// [R7] De-energised: free-run releases the brake; its release re-engages it.
// [R8] No stop-type input ever raises in-position.
// [R9] Deviation clear zeroes deviation, halts at feedback position, drops travel.
// [R10] Ready returns when deviation clear goes inactive.
// [R11] Two-bit stop action: 0 immediate, 1 soft decel, 2 hard decel, 3 both; code: bit 0 stop, bit 1 stop-and-de-energise, 1 = decel.
// [R12] Stop-and-de-energise stops, drops travel, de-energises once stopped while held.
// [R13] Released during deceleration: finish stopping, stay energised, then ready.
// [R14] Released after de-energising: re-energise, then ready.
// [R15] Immediate stop holds the command position latched at detection.
// [R16] Plain stop stops, drops travel; ready after release if stopped while held.
// [R17] Plain stop released during deceleration: stop fully, then ready.
// [R18] Forward block stops forward motion only, reverse block reverse only.
// [R19] Starts toward an active block are ignored; opposite starts accepted.
// [R20] Block action bit: 0 immediate, 1 deceleration stop; default 1.
// [R21] Block inputs raise forward and reverse prohibited flags.
// [R22] Ready after a block stop; opposite start drops ready and moves.
// [R23] Ready means energised, idle and able to take a start.
// [R24] Inputs sampled each control cycle, edges from the previous sample.
//
// Implementation choices: the register addresses and the APB register port.
`include "sesc_map.svh"
`default_nettype none
module sesc_ctrl #(
   parameter int W       = 32,
   parameter int VW      = 16,
   parameter int DIV_CYC = (`SESC_CYCLE_NS + `SESC_CLK_NS - 1) / `SESC_CLK_NS
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         excite_req,
   input  wire logic         free_run,
   input  wire logic         deviation_clear,
   input  wire logic         stop_req,
   input  wire logic         stop_and_deenergise,
   input  wire logic         forward_block,
   input  wire logic         reverse_block,
   input  wire logic [W-1:0] fb_pos,
   output logic              ready,
   output logic              excite_on,
   output logic              brake_release,
   output logic              in_position,
   output logic              fw_prohibit,
   output logic              rv_prohibit,
   output logic              moving,
   output logic      [W-1:0] cmd_pos
);
   localparam int NIN = 7;

   logic [NIN-1:0]        pins_s;
   logic                  exc_s;
   logic                  free_s;
   logic                  clr_s;
   logic                  stop_s;
   logic                  soff_s;
   logic                  fwb_s;
   logic                  rvb_s;
   logic                  stop_prev_r;
   logic                  soff_prev_r;
   logic [15:0]           div_r;
   logic                  tick;
   logic                  brake_fit_r;
   logic [1:0]            ssel_r;
   logic                  blk_dec_r;
   logic [W-1:0]          travel_r;
   logic [VW-1:0]         speed_r;
   logic [VW-1:0]         accel_r;
   logic                  pend_fwd_r;
   logic                  pend_rev_r;
   logic                  soff_off_r;
   sesc_pkg::sesc_state_e st_r;
   sesc_pkg::sesc_state_e st_nxt;
   logic                  want;
   logic                  imm;
   logic                  dcl;
   logic                  start_go;
   logic                  start_rev;
   logic                  mv_rev;
   logic                  mv_done;
   logic                  wr;
   logic                  setup;
   logic                  mapped;
   logic [31:0]           status;
   logic [31:0]           rd_nxt;

   sesc_sync #(
      .W (NIN)
   ) u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_in    ({reverse_block, forward_block, stop_and_deenergise, stop_req,
                   deviation_clear, free_run, excite_req}),
      .level_out (pins_s)
   );
   assign {rvb_s, fwb_s, soff_s, stop_s, clr_s, free_s, exc_s} = pins_s;

   // Control cycle strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= '0;
      end else if (div_r == 16'(DIV_CYC - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end
   assign tick = (div_r == 16'(DIV_CYC - 1));

   // [R24] sample per cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_prev_r <= 1'b0;
         soff_prev_r <= 1'b0;
      end else if (tick) begin
         stop_prev_r <= stop_s;
         soff_prev_r <= soff_s;
      end
   end

   // APB slave: zero wait states, error on unmapped offsets
   assign pready = 1'b1;
   assign setup  = psel && !penable;
   assign wr     = psel && penable && pwrite;
   always_comb begin
      case (paddr)
         `SESC_OFF_CTRL, `SESC_OFF_TRAVEL, `SESC_OFF_SPEED, `SESC_OFF_ACCEL,
         `SESC_OFF_CMD, `SESC_OFF_STATUS, `SESC_OFF_CMDPOS, `SESC_OFF_DEV: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // [R11] stop action select
   // [R20] block action select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brake_fit_r <= 1'b0;
         ssel_r      <= `SESC_RST_SSEL;
         blk_dec_r   <= `SESC_RST_BLK;
         travel_r    <= '0;
         speed_r     <= `SESC_RST_SPEED;
         accel_r     <= `SESC_RST_ACCEL;
      end else if (wr) begin
         case (paddr)
            `SESC_OFF_CTRL: begin
               brake_fit_r <= pwdata[`SESC_CTRL_BRAKE];
               ssel_r      <= pwdata[`SESC_CTRL_SSEL_HI:`SESC_CTRL_SSEL_LO];
               blk_dec_r   <= pwdata[`SESC_CTRL_BLK];
            end
            `SESC_OFF_TRAVEL: begin
               travel_r <= pwdata[W-1:0];
            end
            `SESC_OFF_SPEED: begin
               speed_r <= pwdata[VW-1:0];
            end
            `SESC_OFF_ACCEL: begin
               accel_r <= pwdata[VW-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Start requests wait for the next control cycle; a new write wins over consumption
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_fwd_r <= 1'b0;
         pend_rev_r <= 1'b0;
      end else if (wr && paddr == `SESC_OFF_CMD) begin
         pend_fwd_r <= pwdata[`SESC_CMD_FWD];
         pend_rev_r <= pwdata[`SESC_CMD_REV];
      end else if (tick) begin
         pend_fwd_r <= 1'b0;
         pend_rev_r <= 1'b0;
      end
   end

   // [R19] blocked direction refused
   // [R23] only from ready
   always_comb begin
      start_rev = !pend_fwd_r || fwb_s;
      start_go  = tick && ready &&
                  ((pend_fwd_r && !fwb_s) || (pend_rev_r && !rvb_s));
   end

   // [R11] per-input stop manner
   // [R15] immediate halt freezes position
   // [R18] direction-specific block stop
   always_comb begin
      imm = 1'b0;
      dcl = 1'b0;
      if (stop_s && !stop_prev_r) begin
         if (ssel_r[0]) begin
            dcl = 1'b1;
         end else begin
            imm = 1'b1;
         end
      end
      if (soff_s && !soff_prev_r) begin
         if (ssel_r[1]) begin
            dcl = 1'b1;
         end else begin
            imm = 1'b1;
         end
      end
      if (moving && ((fwb_s && !mv_rev) || (rvb_s && mv_rev))) begin
         if (blk_dec_r) begin
            dcl = 1'b1;
         end else begin
            imm = 1'b1;
         end
      end
      // Losing torque mid-move must not leave the profile running
      if (st_r != sesc_pkg::SESC_ON) begin
         imm = 1'b1;
      end
   end

   // [R9] clear loads feedback position
   sesc_motion #(
      .W  (W),
      .VW (VW)
   ) u_motion (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (tick),
      .start     (start_go),
      .start_rev (start_rev),
      .travel    (travel_r),
      .speed     (speed_r),
      .accel     (accel_r),
      .halt      (tick && imm),
      .decel     (tick && dcl),
      .load      (tick && clr_s),
      .load_pos  (fb_pos),
      .cmd_pos   (cmd_pos),
      .moving    (moving),
      .rev       (mv_rev),
      .done      (mv_done)
   );

   // [R12] de-energise once stopped
   // [R13] release during decel keeps torque
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soff_off_r <= 1'b0;
      end else if (tick) begin
         if (!soff_s) begin
            soff_off_r <= 1'b0;
         end else if (!moving) begin
            soff_off_r <= 1'b1;
         end
      end
   end

   // [R5] free-run removes excitation
   assign want = exc_s && !free_s && !soff_off_r;

   // [R1] energise before ready
   // [R2] excite before brake release
   // [R3] ready drops before de-energise
   // [R4] brake engages before de-energise
   // [R6] free-run follows same order
   // [R14] re-energise after release
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         sesc_pkg::SESC_OFF: begin
            if (want) begin
               st_nxt = sesc_pkg::SESC_ENG;
            end
         end
         sesc_pkg::SESC_ENG: begin
            if (!want) begin
               st_nxt = sesc_pkg::SESC_OFF;
            end else if (brake_fit_r) begin
               st_nxt = sesc_pkg::SESC_REL;
            end else begin
               st_nxt = sesc_pkg::SESC_ON;
            end
         end
         sesc_pkg::SESC_REL: begin
            st_nxt = want ? sesc_pkg::SESC_ON : sesc_pkg::SESC_BRK;
         end
         sesc_pkg::SESC_ON: begin
            if (!want) begin
               st_nxt = sesc_pkg::SESC_DRDY;
            end
         end
         sesc_pkg::SESC_DRDY: begin
            st_nxt = brake_fit_r ? sesc_pkg::SESC_BRK : sesc_pkg::SESC_OFF;
         end
         sesc_pkg::SESC_BRK: begin
            st_nxt = sesc_pkg::SESC_OFF;
         end
         default: begin
            st_nxt = sesc_pkg::SESC_OFF;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= sesc_pkg::SESC_OFF;
      end else if (tick) begin
         st_r <= st_nxt;
      end
   end

   // [R7] free-run releases brake when off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         excite_on     <= 1'b0;
         brake_release <= 1'b0;
      end else begin
         excite_on     <= (st_r != sesc_pkg::SESC_OFF);
         brake_release <= brake_fit_r &&
                          ((st_r == sesc_pkg::SESC_REL) || (st_r == sesc_pkg::SESC_ON) ||
                           (st_r == sesc_pkg::SESC_DRDY) ||
                           (st_r == sesc_pkg::SESC_OFF && free_s));
      end
   end

   // [R10] ready after clear released
   // [R16] ready after stop released
   // [R17] ready at standstill
   // [R22] ready drops on accepted start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready <= 1'b0;
      end else begin
         ready <= (st_r == sesc_pkg::SESC_ON) && !(tick && st_nxt != sesc_pkg::SESC_ON) &&
                  !moving && !start_go && !clr_s && !stop_s && !soff_s;
      end
   end

   // [R8] only a completed move sets in-position
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_position <= 1'b0;
      end else if (mv_done) begin
         in_position <= 1'b1;
      end else if (start_go || (tick && (imm || dcl || clr_s))) begin
         in_position <= 1'b0;
      end
   end

   // [R21] prohibition flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fw_prohibit <= 1'b0;
         rv_prohibit <= 1'b0;
      end else begin
         fw_prohibit <= fwb_s;
         rv_prohibit <= rvb_s;
      end
   end

   always_comb begin
      status                                          = '0;
      status[`SESC_ST_READY]                          = ready;
      status[`SESC_ST_EXCITE]                         = excite_on;
      status[`SESC_ST_BRAKE]                          = brake_release;
      status[`SESC_ST_MOVING]                         = moving;
      status[`SESC_ST_INPOS]                          = in_position;
      status[`SESC_ST_FWPROH]                         = fw_prohibit;
      status[`SESC_ST_RVPROH]                         = rv_prohibit;
      status[`SESC_ST_DIR]                            = mv_rev;
      status[`SESC_ST_STATE_HI:`SESC_ST_STATE_LO]     = st_r;
      rd_nxt = '0;
      case (paddr)
         `SESC_OFF_CTRL: begin
            rd_nxt[`SESC_CTRL_BRAKE]                       = brake_fit_r;
            rd_nxt[`SESC_CTRL_SSEL_HI:`SESC_CTRL_SSEL_LO]  = ssel_r;
            rd_nxt[`SESC_CTRL_BLK]                         = blk_dec_r;
         end
         `SESC_OFF_TRAVEL: rd_nxt = 32'(travel_r);
         `SESC_OFF_SPEED:  rd_nxt = 32'(speed_r);
         `SESC_OFF_ACCEL:  rd_nxt = 32'(accel_r);
         `SESC_OFF_STATUS: rd_nxt = status;
         `SESC_OFF_CMDPOS: rd_nxt = 32'(cmd_pos);
         `SESC_OFF_DEV:    rd_nxt = 32'(cmd_pos - fb_pos);
         default:          rd_nxt = '0;
      endcase
   end

   // Read data captured in setup so it is stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end
   end
endmodule : sesc_ctrl
`default_nettype wire

// file: hw/sesc_map.svh
// Register offsets, field positions, reset values and timing of the stop control
`ifndef SESC_MAP_SVH
`define SESC_MAP_SVH

`define SESC_OFF_CTRL     8'h00
`define SESC_OFF_TRAVEL   8'h04
`define SESC_OFF_SPEED    8'h08
`define SESC_OFF_ACCEL    8'h0C
`define SESC_OFF_CMD      8'h10
`define SESC_OFF_STATUS   8'h14
`define SESC_OFF_CMDPOS   8'h18
`define SESC_OFF_DEV      8'h1C

`define SESC_CTRL_BRAKE   0
`define SESC_CTRL_SSEL_LO 1
`define SESC_CTRL_SSEL_HI 2
`define SESC_CTRL_BLK     3
`define SESC_CMD_FWD      0
`define SESC_CMD_REV      1

`define SESC_ST_READY     0
`define SESC_ST_EXCITE    1
`define SESC_ST_BRAKE     2
`define SESC_ST_MOVING    3
`define SESC_ST_INPOS     4
`define SESC_ST_FWPROH    5
`define SESC_ST_RVPROH    6
`define SESC_ST_DIR       7
`define SESC_ST_STATE_LO  8
`define SESC_ST_STATE_HI  10

`define SESC_RST_SSEL     2'h3
`define SESC_RST_BLK      1'h1
`define SESC_RST_SPEED    16'h0100
`define SESC_RST_ACCEL    16'h0010

`define SESC_CLK_NS       20
`define SESC_CYCLE_NS     1000

`endif

// file: hw/sesc_motion.sv
// Command position generator: ramped moves, deceleration and immediate halt
`default_nettype none
module sesc_motion #(
   parameter int W  = 32,
   parameter int VW = 16
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          tick,
   input  wire logic          start,
   input  wire logic          start_rev,
   input  wire logic [W-1:0]  travel,
   input  wire logic [VW-1:0] speed,
   input  wire logic [VW-1:0] accel,
   input  wire logic          halt,
   input  wire logic          decel,
   input  wire logic          load,
   input  wire logic [W-1:0]  load_pos,
   output logic      [W-1:0]  cmd_pos,
   output logic               moving,
   output logic               rev,
   output logic               done
);
   logic [VW-1:0] vel_r;
   logic [VW-1:0] vel_nxt;
   logic [W-1:0]  rem_r;
   logic          dec_r;
   logic [VW:0]   up;
   logic [W-1:0]  step;
   logic          last;

   always_comb begin
      up = {1'b0, vel_r} + {1'b0, accel};
      if (dec_r) begin
         vel_nxt = (vel_r > accel) ? vel_r - accel : '0;
      end else if (up > {1'b0, speed}) begin
         vel_nxt = speed;
      end else begin
         vel_nxt = up[VW-1:0];
      end
      last = !dec_r && (rem_r <= W'(vel_nxt));
      step = last ? rem_r : W'(vel_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_pos <= '0;
         moving  <= 1'b0;
         rev     <= 1'b0;
         done    <= 1'b0;
         vel_r   <= '0;
         rem_r   <= '0;
         dec_r   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (halt || load) begin
            // Freeze where the command stands, or at load_pos on load; remaining travel is dropped
            moving <= 1'b0;
            vel_r  <= '0;
            rem_r  <= '0;
            dec_r  <= 1'b0;
            if (load) begin
               cmd_pos <= load_pos;
            end
         end else if (start && !moving && travel != '0) begin
            moving <= 1'b1;
            rev    <= start_rev;
            rem_r  <= travel;
            vel_r  <= '0;
            dec_r  <= 1'b0;
         end else if (decel && moving && !dec_r) begin
            dec_r <= 1'b1;
            rem_r <= '0;
         end else if (tick && moving) begin
            cmd_pos <= rev ? cmd_pos - step : cmd_pos + step;
            vel_r   <= vel_nxt;
            rem_r   <= rem_r - step;
            if (last || (dec_r && vel_nxt == '0)) begin
               moving <= 1'b0;
               dec_r  <= 1'b0;
               done   <= last;
            end
         end
      end
   end
endmodule : sesc_motion
`default_nettype wire

// file: hw/sesc_pkg.sv
// Types shared by the stop control design
`default_nettype none
package sesc_pkg;
   typedef enum logic [2:0] {
      SESC_OFF  = 3'h0,
      SESC_ENG  = 3'h1,
      SESC_REL  = 3'h2,
      SESC_ON   = 3'h3,
      SESC_DRDY = 3'h4,
      SESC_BRK  = 3'h5
   } sesc_state_e;
endpackage : sesc_pkg
`default_nettype wire

// file: hw/sesc_sync.sv
// Three-stage input synchroniser; a change is taken when stages two and three agree
`default_nettype none
module sesc_sync #(
   parameter int W = 7
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level_out
);
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_r         <= 1'b0;
            s2_r         <= 1'b0;
            s3_r         <= 1'b0;
            level_out[i] <= 1'b0;
         end else begin
            s1_r <= pin_in[i];
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
               level_out[i] <= s3_r;
            end
         end
      end
   end
endmodule : sesc_sync
`default_nettype wire

// file: testbench/sesc_ctrl_checker.sv
// Port-level checker of excitation, brake and stop sequencing
`default_nettype none
module sesc_ctrl_checker #(
   parameter int W = 32
) (
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         excite_req,
   input wire logic         free_run,
   input wire logic         deviation_clear,
   input wire logic         stop_req,
   input wire logic         stop_and_deenergise,
   input wire logic         forward_block,
   input wire logic         reverse_block,
   input wire logic [W-1:0] fb_pos,
   input wire logic         ready,
   input wire logic         excite_on,
   input wire logic         brake_release,
   input wire logic         in_position,
   input wire logic         fw_prohibit,
   input wire logic         rv_prohibit,
   input wire logic         moving,
   input wire logic [W-1:0] cmd_pos
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stop_any;
   assign stop_any = stop_req | stop_and_deenergise | deviation_clear;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ready_excited_a: assert property (ready |-> excite_on && !moving)
      else $error("ready without an idle energised motor");
   brake_after_exc_a: assert property (
      $rose(brake_release) && !free_run |-> $past(excite_on))
      else $error("brake released before excitation");
   brake_before_off_a: assert property (
      $fell(excite_on) && !free_run |-> !brake_release)
      else $error("excitation removed with brake released");
   no_stop_inpos_a: assert property (
      $rose(in_position) |-> !stop_any && !$past(stop_any, 6))
      else $error("in-position raised by a stop input");
   clear_halt_a: assert property (
      deviation_clear[*8] ##1 deviation_clear[*5] |-> cmd_pos == fb_pos && !moving && !ready)
      else $error("deviation clear did not hold at feedback");
   fw_flag_a: assert property (forward_block[*8] ##1 forward_block[*3] |-> fw_prohibit)
      else $error("forward prohibit flag missing");
   rv_flag_a: assert property (!reverse_block[*8] ##1 !reverse_block[*3] |-> !rv_prohibit)
      else $error("reverse prohibit flag stuck");
   free_cut_a: assert property (
      free_run[*8] ##1 free_run[*8] ##1 free_run[*8] |-> !excite_on && !ready)
      else $error("free-run left windings energised");
   off_settle_a: assert property (
      !excite_req[*8] ##1 !excite_req[*8] ##1 !excite_req[*8] |-> !excite_on && !ready)
      else $error("excitation kept without request");
endmodule : sesc_ctrl_checker

bind sesc_ctrl sesc_ctrl_checker #(.W(W)) sesc_ctrl_checker_i (.pclk, .presetn, .excite_req,
   .free_run, .deviation_clear, .stop_req, .stop_and_deenergise, .forward_block,
   .reverse_block, .fb_pos, .ready, .excite_on, .brake_release, .in_position, .fw_prohibit,
   .rv_prohibit, .moving, .cmd_pos);
`default_nettype wire

// file: testbench/sesc_ctrl_tb.sv
// Self-checking bench for the servo excitation and stop control
`default_nettype none
`include "sesc_map.svh"
module sesc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, er, dec;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, fb_pos, cmd_pos, q;
   logic        excite_req, free_run, deviation_clear, stop_req, stop_and_deenergise;
   logic        forward_block, reverse_block, ready, excite_on, brake_release;
   logic        in_position, fw_prohibit, rv_prohibit, moving;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          n;

   always #10 pclk = ~pclk;

   sesc_ctrl #(.DIV_CYC(4)) sesc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .excite_req, .free_run, .deviation_clear,
      .stop_req, .stop_and_deenergise, .forward_block, .reverse_block, .fb_pos, .ready,
      .excite_on, .brake_release, .in_position, .fw_prohibit, .rv_prohibit, .moving,
      .cmd_pos);
   sesc_host sesc_host_i (.pclk, .excite_req, .free_run, .deviation_clear, .stop_req,
      .stop_and_deenergise, .forward_block, .reverse_block);

   task automatic complete_run();
      $display("Compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("rdata", q, e);
   endtask : rd

   task automatic wait_on(ref logic s, input logic v);
      while (s !== v) @(negedge pclk);
   endtask : wait_on

   task automatic move(input logic [31:0] c);
      apb(1'b1, `SESC_OFF_TRAVEL, 32'h4000);
      apb(1'b1, `SESC_OFF_CMD, c);
      wait_on(moving, 1'b1);
      repeat (40) @(negedge pclk);
   endtask : move

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      fb_pos = 32'h0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SESC_OFF_CTRL, 32'h0000000E);
      rd(`SESC_OFF_SPEED, 32'h00000100);
      rd(8'h40, 32'h0);
      chk("pslverr", er, 1'b1);
      apb(1'b1, `SESC_OFF_CTRL, 32'h0000000F);
      sesc_host_i.drive(0, 1'b1);
      wait_on(ready, 1'b1);
      chk("brake", brake_release, 1'b1);
      apb(1'b1, `SESC_OFF_TRAVEL, 32'h40);
      apb(1'b1, `SESC_OFF_CMD, 32'h1);
      wait_on(moving, 1'b1);
      wait_on(ready, 1'b1);
      chk("inpos", in_position, 1'b1);
      chk("cmdpos", cmd_pos, 32'h40);
      for (int m = 0; m < 8; m++) begin
         dec = m[2] ? m[1] : m[0];
         apb(1'b1, `SESC_OFF_CTRL, {28'h0, 1'b1, m[1:0], 1'b1});
         move(32'h1);
         sesc_host_i.drive(3 + m[2], 1'b1);
         n = 0;
         while (moving !== 1'b0) begin
            @(negedge pclk);
            n++;
            if (n == 14 && dec)
               sesc_host_i.drive(3 + m[2], 1'b0);
         end
         chk("decel", n > 12, dec);
         chk("inpos", in_position, 1'b0);
         if (!dec) begin
            if (m[2])
               wait_on(excite_on, 1'b0);
            chk("held", ready, 1'b0);
            sesc_host_i.drive(3 + m[2], 1'b0);
         end
         wait_on(ready, 1'b1);
         chk("exc", excite_on, 1'b1);
         chk("travel", moving, 1'b0);
      end
      move(32'h1);
      sesc_host_i.drive(6, 1'b1);
      repeat (20) @(negedge pclk);
      chk("fwdmove", moving, 1'b1);
      chk("rvflag", rv_prohibit, 1'b1);
      sesc_host_i.drive(6, 1'b0);
      sesc_host_i.drive(5, 1'b1);
      wait_on(ready, 1'b1);
      chk("fwflag", fw_prohibit, 1'b1);
      apb(1'b1, `SESC_OFF_CMD, 32'h1);
      repeat (16) @(negedge pclk);
      chk("fwdstart", moving, 1'b0);
      apb(1'b1, `SESC_OFF_CMD, 32'h2);
      wait_on(moving, 1'b1);
      chk("revstart", ready, 1'b0);
      wait_on(ready, 1'b1);
      sesc_host_i.drive(5, 1'b0);
      move(32'h1);
      sesc_host_i.drive(2, 1'b1);
      fb_pos <= 32'h00005A5A;
      wait_on(moving, 1'b0);
      repeat (16) @(negedge pclk);
      chk("clrrdy", ready, 1'b0);
      sesc_host_i.drive(2, 1'b0);
      wait_on(ready, 1'b1);
      chk("clrpos", cmd_pos, 32'h00005A5A);
      rd(`SESC_OFF_DEV, 32'h0);
      sesc_host_i.drive(1, 1'b1);
      wait_on(excite_on, 1'b0);
      repeat (12) @(negedge pclk);
      chk("freebrk", brake_release, 1'b1);
      sesc_host_i.drive(1, 1'b0);
      wait_on(ready, 1'b1);
      sesc_host_i.drive(0, 1'b0);
      wait_on(excite_on, 1'b0);
      chk("offbrk", brake_release, 1'b0);
      sesc_host_i.drive(1, 1'b1);
      wait_on(brake_release, 1'b1);
      chk("offfree", excite_on, 1'b0);
      sesc_host_i.drive(1, 1'b0);
      wait_on(brake_release, 1'b0);
      chk("reheld", excite_on, 1'b0);
      complete_run();
   end
endmodule : sesc_ctrl_tb
`default_nettype wire

// file: testbench/sesc_host.sv
// Host controller model driving the discrete command inputs
`default_nettype none
module sesc_host (
   input  wire logic pclk,
   output logic      excite_req,
   output logic      free_run,
   output logic      deviation_clear,
   output logic      stop_req,
   output logic      stop_and_deenergise,
   output logic      forward_block,
   output logic      reverse_block
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] lvl_r = 7'h00;
   assign {reverse_block, forward_block, stop_and_deenergise, stop_req, deviation_clear,
           free_run, excite_req} = lvl_r;
   // levels change only after an edge
   task automatic drive(input int idx, input logic v);
      @(posedge pclk);
      lvl_r[idx] <= v;
   endtask : drive
endmodule : sesc_host
`default_nettype wire
